/* hw/opd_top.v */
// Overview of operation
// - source select bit routes first synthesizer at 0, second at 1; resets 1.
// - channel 2 format: 0 off, 1 ac differential, 2 hcsl, 3 cmos; reset 1.
// - channel 2 mode a bits 4:3 reset 2: tail current or positive leg state.
// - channel 2 mode b bits 2:1 reset 0: hcsl load or negative leg state.
// - channel 3 format bits 6:5 reset 1, mode a bits 4:3 reset 2.
// - channel 3 mode b bits 2:1 reset 0, decoded like channel 2.
`timescale 1ns/1ns
`default_nettype none
`include "opd_consts.vh"

module opd_top (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // write address
    input wire [`OPD_ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // write data
    input wire [`OPD_DATA_W-1:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // read address
    input wire [`OPD_ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // read data
    output reg [`OPD_DATA_W-1:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // pair source
    output reg pair23_source_select,
    // channel 2 fields
    output reg [1:0] ch2_format,
    output reg [1:0] ch2_drive_mode_a,
    output reg [1:0] ch2_drive_mode_b,
    // channel 2 driver controls
    output reg ch2_drv_on,
    output reg [4:0] ch2_tail_ma,
    output reg [7:0] ch2_rload_ohm,
    output reg [2:0] ch2_outp_ctl,
    output reg [2:0] ch2_outn_ctl,
    // channel 3 fields
    output reg [1:0] ch3_format,
    output reg [1:0] ch3_drive_mode_a,
    output reg [1:0] ch3_drive_mode_b,
    // channel 3 driver controls
    output reg ch3_drv_on,
    output reg [4:0] ch3_tail_ma,
    output reg [7:0] ch3_rload_ohm,
    output reg [2:0] ch3_outp_ctl,
    output reg [2:0] ch3_outn_ctl
);

    // ==========================================================
    // address decode, shared by both channels of the bus
    function [1:0] reg_sel;
        input [`OPD_ADDR_W-1:0] addr;
        begin
            if (addr[1:0] != 2'h0)
                reg_sel = `OPD_SEL_NONE;
            else if ({2'h0, addr[`OPD_ADDR_W-1:2]} == `OPD_IDX_CH2_CTL)
                reg_sel = `OPD_SEL_CH2;
            else if ({2'h0, addr[`OPD_ADDR_W-1:2]} == `OPD_IDX_CH3_CTL)
                reg_sel = `OPD_SEL_CH3;
            else if ({2'h0, addr[`OPD_ADDR_W-1:2]} == `OPD_IDX_STATUS)
                reg_sel = `OPD_SEL_STAT;
            else
                reg_sel = `OPD_SEL_NONE;
        end
    endfunction

    // ==========================================================
    // stored configuration
    reg [7:0] ch2_ctl_reg;
    reg [7:0] ch3_ctl_reg;
    reg aw_hold_reg;
    reg w_hold_reg;
    reg [`OPD_ADDR_W-1:0] awaddr_reg;
    reg [7:0] wbyte_reg;
    reg wlane_reg;

    wire [1:0] wr_sel;
    wire do_write;
    wire [1:0] rd_sel;
    wire [1:0] c2_fmt;
    wire [1:0] c2_ma;
    wire [1:0] c2_mb;
    wire [1:0] c3_fmt;
    wire [1:0] c3_ma;
    wire [1:0] c3_mb;
    wire c2_on;
    wire [4:0] c2_tail;
    wire [7:0] c2_rload;
    wire [2:0] c2_p;
    wire [2:0] c2_n;
    wire c3_on;
    wire [4:0] c3_tail;
    wire [7:0] c3_rload;
    wire [2:0] c3_p;
    wire [2:0] c3_n;
    wire [7:0] status_byte;

    assign wr_sel = reg_sel(awaddr_reg);
    assign rd_sel = reg_sel(s_axi_araddr);
    assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

    assign c2_fmt = ch2_ctl_reg[`OPD_FMT_HI:`OPD_FMT_LO];
    assign c2_ma = ch2_ctl_reg[`OPD_MODEA_HI:`OPD_MODEA_LO];
    assign c2_mb = ch2_ctl_reg[`OPD_MODEB_HI:`OPD_MODEB_LO];
    assign c3_fmt = ch3_ctl_reg[`OPD_FMT_HI:`OPD_FMT_LO];
    assign c3_ma = ch3_ctl_reg[`OPD_MODEA_HI:`OPD_MODEA_LO];
    assign c3_mb = ch3_ctl_reg[`OPD_MODEB_HI:`OPD_MODEB_LO];

    // live view of what the drivers are doing, from the output flops
    assign status_byte = {3'h0, ch3_outn_ctl[2] | ch3_outp_ctl[2],
        ch3_drv_on, ch2_outn_ctl[2] | ch2_outp_ctl[2], ch2_drv_on,
        pair23_source_select};

    // ==========================================================
    // per-channel driver decode
    opd_decode u_ch2_dec (
        .format(c2_fmt),
        .mode_a(c2_ma),
        .mode_b(c2_mb),
        .drv_on(c2_on),
        .tail_ma(c2_tail),
        .rload_ohm(c2_rload),
        .outp_ctl(c2_p),
        .outn_ctl(c2_n)
    );

    opd_decode u_ch3_dec (
        .format(c3_fmt),
        .mode_a(c3_ma),
        .mode_b(c3_mb),
        .drv_on(c3_on),
        .tail_ma(c3_tail),
        .rload_ohm(c3_rload),
        .outp_ctl(c3_p),
        .outn_ctl(c3_n)
    );

    // ==========================================================
    // write path: address and data may arrive in either order
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `OPD_RESP_OKAY;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= {`OPD_ADDR_W{1'b0}};
            wbyte_reg <= 8'h00;
            wlane_reg <= 1'b0;
            ch2_ctl_reg <= `OPD_CH2_RESET;
            ch3_ctl_reg <= `OPD_CH3_RESET;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_reg <= 1'b1;
                wbyte_reg <= s_axi_wdata[7:0];
                wlane_reg <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_sel == `OPD_SEL_CH2 || wr_sel == `OPD_SEL_CH3) ?
                    `OPD_RESP_OKAY : `OPD_RESP_SLVERR;
                // only byte lane 0 carries a register; reserved bits never store
                if (wlane_reg && wr_sel == `OPD_SEL_CH2)
                    ch2_ctl_reg <= wbyte_reg & `OPD_CH2_MASK;
                if (wlane_reg && wr_sel == `OPD_SEL_CH3)
                    ch3_ctl_reg <= wbyte_reg & `OPD_CH3_MASK;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // read path: one outstanding read, answered on the next edge
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `OPD_RESP_OKAY;
            s_axi_rdata <= {`OPD_DATA_W{1'b0}};
        end
        else
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `OPD_RESP_OKAY;
                case (rd_sel)
                    `OPD_SEL_CH2:
                        s_axi_rdata <= {24'h000000, ch2_ctl_reg & `OPD_CH2_MASK};
                    `OPD_SEL_CH3:
                        s_axi_rdata <= {24'h000000, ch3_ctl_reg & `OPD_CH3_MASK};
                    `OPD_SEL_STAT:
                        s_axi_rdata <= {24'h000000, status_byte};
                    default:
                    begin
                        s_axi_rdata <= {`OPD_DATA_W{1'b0}};
                        s_axi_rresp <= `OPD_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // driver control outputs, registered so the analogue side sees clean levels
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pair23_source_select <= `OPD_SRC_SECOND;
            ch2_format <= `OPD_FMT_ACDIFF;
            ch2_drive_mode_a <= `OPD_MODE_2;
            ch2_drive_mode_b <= `OPD_MODE_0;
            ch3_format <= `OPD_FMT_ACDIFF;
            ch3_drive_mode_a <= `OPD_MODE_2;
            ch3_drive_mode_b <= `OPD_MODE_0;
            ch2_drv_on <= 1'b1;
            ch2_tail_ma <= `OPD_TAIL_MA_2;
            ch2_rload_ohm <= 8'h00;
            ch2_outp_ctl <= 3'h0;
            ch2_outn_ctl <= 3'h0;
            ch3_drv_on <= 1'b1;
            ch3_tail_ma <= `OPD_TAIL_MA_2;
            ch3_rload_ohm <= 8'h00;
            ch3_outp_ctl <= 3'h0;
            ch3_outn_ctl <= 3'h0;
        end
        else
        begin
            pair23_source_select <= ch2_ctl_reg[`OPD_SRC_BIT];
            ch2_format <= c2_fmt;
            ch2_drive_mode_a <= c2_ma;
            ch2_drive_mode_b <= c2_mb;
            ch3_format <= c3_fmt;
            ch3_drive_mode_a <= c3_ma;
            ch3_drive_mode_b <= c3_mb;
            ch2_drv_on <= c2_on;
            ch2_tail_ma <= c2_tail;
            ch2_rload_ohm <= c2_rload;
            ch2_outp_ctl <= c2_p;
            ch2_outn_ctl <= c2_n;
            ch3_drv_on <= c3_on;
            ch3_tail_ma <= c3_tail;
            ch3_rload_ohm <= c3_rload;
            ch3_outp_ctl <= c3_p;
            ch3_outn_ctl <= c3_n;
        end
    end

endmodule
`default_nettype wire

/* hw/opd_consts.vh */
`ifndef OPD_CONSTS_VH
`define OPD_CONSTS_VH

// ==========================================================
// bus geometry
`define OPD_ADDR_W 8
`define OPD_DATA_W 32
`define OPD_RESP_OKAY 2'h0
`define OPD_RESP_SLVERR 2'h2

// ==========================================================
// register indices; byte address is four times the index
`define OPD_IDX_CH2_CTL 8'h22
`define OPD_IDX_CH3_CTL 8'h23
`define OPD_IDX_STATUS 8'h24
`define OPD_SEL_NONE 2'h0
`define OPD_SEL_CH2 2'h1
`define OPD_SEL_CH3 2'h2
`define OPD_SEL_STAT 2'h3

// ==========================================================
// control register fields
`define OPD_SRC_BIT 7
`define OPD_FMT_HI 6
`define OPD_FMT_LO 5
`define OPD_MODEA_HI 4
`define OPD_MODEA_LO 3
`define OPD_MODEB_HI 2
`define OPD_MODEB_LO 1
`define OPD_CH2_MASK 8'hfe
`define OPD_CH3_MASK 8'h7e
`define OPD_CH2_RESET 8'hb0
`define OPD_CH3_RESET 8'h30

// ==========================================================
// field codes
`define OPD_FMT_OFF 2'h0
`define OPD_FMT_ACDIFF 2'h1
`define OPD_FMT_HCSL 2'h2
`define OPD_FMT_CMOS 2'h3
`define OPD_SRC_FIRST 1'h0
`define OPD_SRC_SECOND 1'h1
`define OPD_MODE_0 2'h0
`define OPD_MODE_1 2'h1
`define OPD_MODE_2 2'h2
`define OPD_MODE_3 2'h3

// ==========================================================
// analogue settings in plain units
`define OPD_TAIL_MA_0 5'h04
`define OPD_TAIL_MA_1 5'h06
`define OPD_TAIL_MA_2 5'h08
`define OPD_TAIL_MA_3_HCSL 5'h10
`define OPD_TAIL_MA_3_DIFF 5'h08
`define OPD_RLOAD_1 8'h32
`define OPD_RLOAD_2 8'h64
`define OPD_RLOAD_3 8'hc8

`endif

/* hw/opd_decode.v */
`timescale 1ns/1ns
`default_nettype none
`include "opd_consts.vh"

module opd_decode (
    // stored fields
    input wire [1:0] format,
    input wire [1:0] mode_a,
    input wire [1:0] mode_b,
    // driver controls
    output reg drv_on,
    output reg [4:0] tail_ma,
    output reg [7:0] rload_ohm,
    output reg [2:0] outp_ctl,
    output reg [2:0] outn_ctl
);

    // ==========================================================
    // single-ended leg: {oe, run, invert}
    function [2:0] cmos_leg;
        input [1:0] code;
        begin
            case (code)
                `OPD_MODE_0: cmos_leg = 3'h0;
                `OPD_MODE_1: cmos_leg = 3'h4;
                `OPD_MODE_2: cmos_leg = 3'h7;
                default: cmos_leg = 3'h6;
            endcase
        end
    endfunction

    // ==========================================================
    always @*
    begin
        drv_on = (format != `OPD_FMT_OFF);
        tail_ma = 5'h00;
        rload_ohm = 8'h00;
        outp_ctl = 3'h0;
        outn_ctl = 3'h0;
        case (format)
            `OPD_FMT_ACDIFF, `OPD_FMT_HCSL:
            begin
                case (mode_a)
                    `OPD_MODE_0: tail_ma = `OPD_TAIL_MA_0;
                    `OPD_MODE_1: tail_ma = `OPD_TAIL_MA_1;
                    `OPD_MODE_2: tail_ma = `OPD_TAIL_MA_2;
                    default: tail_ma = (format == `OPD_FMT_HCSL) ?
                        `OPD_TAIL_MA_3_HCSL : `OPD_TAIL_MA_3_DIFF;
                endcase
                // load only applies to hcsl; code 0 leaves it open
                if (format == `OPD_FMT_HCSL)
                begin
                    case (mode_b)
                        `OPD_MODE_1: rload_ohm = `OPD_RLOAD_1;
                        `OPD_MODE_2: rload_ohm = `OPD_RLOAD_2;
                        `OPD_MODE_3: rload_ohm = `OPD_RLOAD_3;
                        default: rload_ohm = 8'h00;
                    endcase
                end
            end
            `OPD_FMT_CMOS:
            begin
                outp_ctl = cmos_leg(mode_a);
                outn_ctl = cmos_leg(mode_b);
            end
            default:
            begin
                tail_ma = 5'h00;
            end
        endcase
    end

endmodule
`default_nettype wire

/* test/opd_checker.sv */
`timescale 1ns/1ns
`default_nettype none
`include "opd_consts.vh"

module opd_checker (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // read data
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    // channel 2
    input wire logic pair23_source_select,
    input wire logic [1:0] ch2_format,
    input wire logic [1:0] ch2_drive_mode_a,
    input wire logic [1:0] ch2_drive_mode_b,
    input wire logic ch2_drv_on,
    input wire logic [4:0] ch2_tail_ma,
    input wire logic [7:0] ch2_rload_ohm,
    input wire logic [2:0] ch2_outp_ctl,
    // channel 3
    input wire logic [1:0] ch3_format,
    input wire logic [1:0] ch3_drive_mode_a,
    input wire logic [1:0] ch3_drive_mode_b,
    input wire logic ch3_drv_on,
    input wire logic [2:0] ch3_outn_ctl
);
    // ==========================================================
    // field groups; decode is only judged once the fields have held
    // for two edges, so a write in flight is never caught half way
    wire [5:0] f2 = {ch2_format, ch2_drive_mode_a, ch2_drive_mode_b};
    wire [5:0] f3 = {ch3_format, ch3_drive_mode_a, ch3_drive_mode_b};

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ==========================================================
    // properties
    reset_fields_a: assert property (
        $rose(aresetn) |-> pair23_source_select && f2 == 6'h18 && f3 == 6'h18)
        else $error("fields wrong after reset");
    ch2_enable_a: assert property (
        $stable(f2) [*2] |-> ch2_drv_on == (ch2_format != 2'h0))
        else $error("ch2 enable wrong");
    ch2_tail_a: assert property (
        $stable(f2) [*2] ##0 ch2_format inside {2'h1, 2'h2} |->
        ch2_tail_ma == (ch2_drive_mode_a == 2'h3 ? (ch2_format[1] ? 5'h10 : 5'h08)
        : 5'h04 + {2'h0, ch2_drive_mode_a, 1'b0}))
        else $error("ch2 tail current wrong");
    ch2_load_a: assert property (
        $stable(f2) [*2] ##0 ch2_format == 2'h2 |->
        ch2_rload_ohm == (ch2_drive_mode_b == 2'h0 ? 8'h00 : 8'h19 << ch2_drive_mode_b))
        else $error("ch2 load wrong");
    ch2_pos_leg_a: assert property (
        $stable(f2) [*2] ##0 ch2_format == 2'h3 |-> ch2_outp_ctl == (ch2_drive_mode_a == 2'h0
        ? 3'h0 : {1'b1, ch2_drive_mode_a[1], ch2_drive_mode_a == 2'h2}))
        else $error("ch2 positive leg wrong");
    ch3_enable_a: assert property (
        $stable(f3) [*2] |-> ch3_drv_on == (ch3_format != 2'h0))
        else $error("ch3 enable wrong");
    ch3_neg_leg_a: assert property (
        $stable(f3) [*2] ##0 ch3_format == 2'h3 |-> ch3_outn_ctl == (ch3_drive_mode_b == 2'h0
        ? 3'h0 : {1'b1, ch3_drive_mode_b[1], ch3_drive_mode_b == 2'h2}))
        else $error("ch3 negative leg wrong");
    upper_zero_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
endmodule

bind opd_top opd_checker i_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
    .pair23_source_select(pair23_source_select), .ch2_format(ch2_format),
    .ch2_drive_mode_a(ch2_drive_mode_a), .ch2_drive_mode_b(ch2_drive_mode_b),
    .ch2_drv_on(ch2_drv_on), .ch2_tail_ma(ch2_tail_ma), .ch2_rload_ohm(ch2_rload_ohm),
    .ch2_outp_ctl(ch2_outp_ctl), .ch3_format(ch3_format), .ch3_drive_mode_a(ch3_drive_mode_a),
    .ch3_drive_mode_b(ch3_drive_mode_b), .ch3_drv_on(ch3_drv_on), .ch3_outn_ctl(ch3_outn_ctl)
);

`default_nettype wire

/* test/opd_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "opd_consts.vh"

module tb;
    // ==========================================================
    // design ports
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic pair23_source_select, ch2_drv_on, ch3_drv_on;
    logic [1:0] ch2_format, ch2_drive_mode_a, ch2_drive_mode_b;
    logic [1:0] ch3_format, ch3_drive_mode_a, ch3_drive_mode_b;
    logic [4:0] ch2_tail_ma, ch3_tail_ma;
    logic [7:0] ch2_rload_ohm, ch3_rload_ohm;
    logic [2:0] ch2_outp_ctl, ch2_outn_ctl, ch3_outp_ctl, ch3_outn_ctl;

    // ==========================================================
    // reference model
    int n_mismatch = 0, checks_done = 0;
    logic [7:0] m2, m3;
    logic [31:0] d;
    int tails [4] = '{4, 6, 8, 16};
    int loads [4] = '{0, 50, 100, 200};
    logic [2:0] legs [4] = '{3'h0, 3'h4, 3'h7, 3'h6};

    opd_top i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .pair23_source_select(pair23_source_select),
        .ch2_format(ch2_format), .ch2_drive_mode_a(ch2_drive_mode_a),
        .ch2_drive_mode_b(ch2_drive_mode_b), .ch2_drv_on(ch2_drv_on),
        .ch2_tail_ma(ch2_tail_ma), .ch2_rload_ohm(ch2_rload_ohm),
        .ch2_outp_ctl(ch2_outp_ctl), .ch2_outn_ctl(ch2_outn_ctl),
        .ch3_format(ch3_format), .ch3_drive_mode_a(ch3_drive_mode_a),
        .ch3_drive_mode_b(ch3_drive_mode_b), .ch3_drv_on(ch3_drv_on),
        .ch3_tail_ma(ch3_tail_ma), .ch3_rload_ohm(ch3_rload_ohm),
        .ch3_outp_ctl(ch3_outp_ctl), .ch3_outn_ctl(ch3_outn_ctl)
    );

    initial forever #5 aclk = ~aclk;

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            checks_done++;
            if (seen !== exp)
            begin
                n_mismatch++;
                $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
            end
        end
    endtask

    // {enable, tail, load, positive leg, negative leg}
    function automatic logic [19:0] dec(input logic [7:0] c);
        logic [1:0] f;
        logic [4:0] t;
        begin
            f = c[6:5];
            t = (f == 2'h0 || f == 2'h3) ? 5'h0 : 5'(tails[c[4:3]]);
            if (f == 2'h1 && c[4:3] == 2'h3)
                t = 5'h08;
            dec = {f != 2'h0, t, f == 2'h2 ? 8'(loads[c[2:1]]) : 8'h0,
                   f == 2'h3 ? legs[c[4:3]] : 3'h0, f == 2'h3 ? legs[c[2:1]] : 3'h0};
        end
    endfunction

    function automatic logic [31:0] stat();
        logic [19:0] a, b;
        begin
            a = dec(m2);
            b = dec(m3);
            stat = {27'h0, b[5] | b[2], b[19], a[5] | a[2], a[19], m2[7]};
        end
    endfunction

    // ==========================================================
    // bus tasks; each starts on a fresh edge so no strobe is driven twice in a step
    task axw(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] s,
             input logic [1:0] er);
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= dt;
            s_axi_wstrb <= s;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do
            begin
                @(posedge aclk);
                if (s_axi_awready === 1'b1)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wready === 1'b1)
                    s_axi_wvalid <= 1'b0;
            end
            while (s_axi_bvalid !== 1'b1);
            s_axi_bready <= 1'b0;
            chk(32'(s_axi_bresp), 32'(er));
        end
    endtask

    task axr(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do
            begin
                @(posedge aclk);
                if (s_axi_arready === 1'b1)
                    s_axi_arvalid <= 1'b0;
            end
            while (s_axi_rvalid !== 1'b1);
            s_axi_rready <= 1'b0;
            chk(s_axi_rdata, ex);
            chk(32'(s_axi_rresp), 32'(er));
        end
    endtask

    task check_all;
        begin
            repeat (3) @(posedge aclk);
            #1;
            chk({12'h0, ch2_drv_on, ch2_tail_ma, ch2_rload_ohm, ch2_outp_ctl, ch2_outn_ctl},
                32'(dec(m2)));
            chk({12'h0, ch3_drv_on, ch3_tail_ma, ch3_rload_ohm, ch3_outp_ctl, ch3_outn_ctl},
                32'(dec(m3)));
            chk({19'h0, pair23_source_select, ch2_format, ch2_drive_mode_a, ch2_drive_mode_b,
                ch3_format, ch3_drive_mode_a, ch3_drive_mode_b},
                {19'h0, m2[7], m2[6:1], m3[6:1]});
            axr(8'h88, 32'(m2), `OPD_RESP_OKAY);
            axr(8'h8c, 32'(m3), `OPD_RESP_OKAY);
            axr(8'h90, stat(), `OPD_RESP_OKAY);
        end
    endtask

    task final_report;
        begin
            $display("checks %0d mismatches %0d", checks_done, n_mismatch);
            if (n_mismatch == 0 && checks_done > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        int i;
        d = $urandom(55);
        m2 = `OPD_CH2_RESET;
        m3 = `OPD_CH3_RESET;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        check_all;
        // every format against every mode code; reserved and upper bits random
        for (i = 0; i < 16; i++)
        begin
            d = $urandom;
            d[7:1] = {i[0], i[1:0], i[3:2], ~i[3:2]};
            axw(8'h88, d, 4'h1, `OPD_RESP_OKAY);
            m2 = d[7:0] & `OPD_CH2_MASK;
            d = $urandom;
            d[6:1] = {i[3:2], i[1:0], ~i[1:0]};
            axw(8'h8c, d, 4'h1, `OPD_RESP_OKAY);
            m3 = d[7:0] & `OPD_CH3_MASK;
            check_all;
        end
        // refused or masked writes must leave the registers alone
        d = $urandom;
        axw(8'h88, d, 4'he, `OPD_RESP_OKAY);
        axw(8'h94, d, 4'hf, `OPD_RESP_SLVERR);
        axw(8'h90, d, 4'hf, `OPD_RESP_SLVERR);
        axw(8'h8a, d, 4'hf, `OPD_RESP_SLVERR);
        axr(8'h94, 32'h0, `OPD_RESP_SLVERR);
        check_all;
        // second reset in mid-run
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        m2 = `OPD_CH2_RESET;
        m3 = `OPD_CH3_RESET;
        check_all;
        final_report;
    end

    // the run needs about 400 cycles; this cuts a hang off well past that
    initial
    begin
        #100000;
        n_mismatch++;
        final_report;
    end
endmodule

`default_nettype wire
